// ==== usb_sie_pkg.sv ====
// Constants and types for the USB address and endpoint block
package usb_sie_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] io_addr_t;
  typedef logic [6:0] dev_addr_t;
  typedef logic [3:0] endp_t;
  typedef logic [3:0] mode_t;
  typedef logic [2:0] slot_t;
  typedef logic [1:0] cfg_t;
  typedef enum logic [1:0] {
    TOK_NONE = 2'h0,
    TOK_OUT = 2'h1,
    TOK_IN = 2'h2,
    TOK_SETUP = 2'h3
  } tok_kind_t;
  // Register offsets
  localparam io_addr_t ADDR_DEV_A = 8'h10;
  localparam io_addr_t ADDR_EP0_A = 8'h12;
  localparam io_addr_t ADDR_DEV_B = 8'h40;
  localparam io_addr_t ADDR_EP0_B = 8'h42;
  localparam io_addr_t ADDR_USB_CTRL = 8'h1f;
  localparam byte_t RESET_BYTE = 8'h00;
  // Field positions
  localparam int DEV_EN_BIT = 7;
  localparam int CTRL_SIZE_BIT = 7;
  localparam int CTRL_COUNT_BIT = 6;
  localparam int CFG_SIZE = 1;
  localparam int CFG_COUNT = 0;
  localparam int FLAG_SETUP = 7;
  localparam int FLAG_IN = 6;
  localparam int FLAG_OUT = 5;
  localparam int FLAG_ACK = 4;
  // Decoded register select positions
  localparam int SEL_DEV_A = 0;
  localparam int SEL_EP0_A = 1;
  localparam int SEL_DEV_B = 2;
  localparam int SEL_EP0_B = 3;
  localparam int SEL_CTRL = 4;
  // Endpoint slots
  localparam slot_t SLOT_A0 = 3'h0;
  localparam slot_t SLOT_A1 = 3'h1;
  localparam slot_t SLOT_A2 = 3'h2;
  localparam slot_t SLOT_A3 = 3'h3;
  localparam slot_t SLOT_A4 = 3'h4;
  localparam slot_t SLOT_B0 = 3'h5;
  localparam slot_t SLOT_B1 = 3'h6;
  localparam endp_t TOP_EP_A_SPLIT = 4'h2;
  localparam endp_t TOP_EP_A_FIVE = 4'h4;
  localparam endp_t TOP_EP_B = 4'h1;
  // FIFO base per config {size,count}, slot order A0..A4,B0,B1
  localparam byte_t RAM_BASE [4][7] = '{
    '{8'hf8, 8'hf0, 8'he8, 8'h00, 8'h00, 8'he0, 8'hd8},
    '{8'hf8, 8'hf0, 8'he8, 8'he0, 8'hd8, 8'h00, 8'h00},
    '{8'hb8, 8'hc0, 8'he0, 8'h00, 8'h00, 8'ha8, 8'hb0},
    '{8'hb8, 8'hc0, 8'he0, 8'ha8, 8'hb0, 8'h00, 8'h00}};
  localparam logic [5:0] FIFO_SMALL = 6'h08;
  localparam logic [5:0] FIFO_LARGE = 6'h20;
  // CPU stall per byte written by the engine
  localparam logic [1:0] BYTE_STALL_CYCLES = 2'h3;
endpackage

// ==== usb_sie_endpoint_map.sv ====
// Address match, endpoint zero mode registers and FIFO placement
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Two device address registers, A at 0x10 and B at 0x40.
// - Default configuration: address A owns three endpoints, B owns two.
// - Reset clears both address registers: address zero, disabled.
// - Traffic to an address is ignored until its enable bit is set.
// - Control register bits 7 and 6 select endpoint and FIFO layout.
// - Size bit gives A1 and A2 32-byte FIFOs; others stay 8 bytes.
// - Count bit: address A alone answers, endpoints A0 to A4.
// - Default layout: B1, B0, A2, A1, A0 in 8-byte slots upward.
// - Each byte the engine writes stalls the processor three cycles.
// - Endpoint 0 of each address is the control endpoint.
// - Endpoint 0 is bidirectional; other endpoints take one direction (token match here accepts IN and OUT on any endpoint).
// - Endpoint mode registers reset to zero.
// - Two-address layouts: A0 and B0 registers use control format.
// - Low four mode bits steer how endpoint 0 answers.
// - ACK flag sets when a transaction ends with ACK.
// - OUT token sets the OUT-received flag only.
// - IN and SETUP tokens set their flags; CPU write clears SETUP.
// - Engine-updated low seven bits refuse writes until a read.
// - Five-endpoint layouts: B0 location is endpoint 3 mode register.
module usb_sie_endpoint_map
(
  input wire logic clk,
  input wire logic nrst,
  input wire usb_sie_pkg::io_addr_t io_addr,
  input wire usb_sie_pkg::byte_t io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output var usb_sie_pkg::byte_t io_rdata,
  input wire logic tok_valid,
  input wire usb_sie_pkg::tok_kind_t tok_kind,
  input wire usb_sie_pkg::dev_addr_t tok_addr,
  input wire usb_sie_pkg::endp_t tok_endp,
  input wire logic txn_ack,
  input wire logic txn_done,
  input wire logic rx_valid,
  input wire usb_sie_pkg::byte_t rx_data,
  output var logic rx_ready,
  output var logic txn_hit,
  output var usb_sie_pkg::slot_t txn_slot,
  output var usb_sie_pkg::mode_t txn_mode,
  output var logic ram_we,
  output var usb_sie_pkg::byte_t ram_addr,
  output var usb_sie_pkg::byte_t ram_wdata,
  output var logic cpu_stall
);
  import usb_sie_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } wr_state_t;

  localparam slot_t CTRL_SLOT [2] = '{SLOT_A0, SLOT_B0};

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [4:0] reg_sel(input io_addr_t a);
    logic [4:0] s;
    s = 5'h00;
    s[SEL_DEV_A] = (a == ADDR_DEV_A);
    s[SEL_EP0_A] = (a == ADDR_EP0_A);
    s[SEL_DEV_B] = (a == ADDR_DEV_B);
    s[SEL_EP0_B] = (a == ADDR_EP0_B);
    s[SEL_CTRL] = (a == ADDR_USB_CTRL);
    return s;
  endfunction

  function automatic logic [5:0] slot_size(input cfg_t c, input slot_t s);
    logic big;
    big = c[CFG_SIZE] && (s == SLOT_A1 || s == SLOT_A2);
    return big ? FIFO_LARGE : FIFO_SMALL;
  endfunction

  // ****************************************
  // State
  // ****************************************
  byte_t dev_addr_ff [2];
  byte_t nxt_dev_addr [2];
  byte_t ep0_ff [2];
  byte_t nxt_ep0 [2];
  logic lock_ff [2];
  logic nxt_lock [2];
  cfg_t cfg_ff;
  cfg_t nxt_cfg;
  byte_t rdata_ff;
  byte_t nxt_rdata;
  logic active_ff;
  logic nxt_active;
  slot_t slot_ff;
  slot_t nxt_slot;
  tok_kind_t kind_ff;
  tok_kind_t nxt_kind;
  cfg_t txn_cfg_ff;
  cfg_t nxt_txn_cfg;
  mode_t mode_ff;
  mode_t nxt_mode;
  wr_state_t state_ff;
  wr_state_t nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [5:0] idx_ff;
  logic [5:0] nxt_idx;
  logic we_ff;
  logic nxt_we;
  byte_t waddr_ff;
  byte_t nxt_waddr;
  byte_t wdata_ff;
  byte_t nxt_wdata;
  logic stall_ff;
  logic ready_ff;

  logic [4:0] sel;
  logic five_ep;
  logic hit_a;
  logic hit_b;
  logic tok_take;
  slot_t tok_slot;
  logic txn_end;
  logic byte_take;

  // ****************************************
  // Token match
  // ****************************************
  always_comb
  begin
    sel = reg_sel(io_addr);
    five_ep = cfg_ff[CFG_COUNT];
    txn_end = active_ff && (txn_ack || txn_done);
    hit_a = tok_valid && dev_addr_ff[0][DEV_EN_BIT]
      && dev_addr_ff[0][6:0] == tok_addr
      && tok_endp <= (five_ep ? TOP_EP_A_FIVE : TOP_EP_A_SPLIT);
    hit_b = tok_valid && !five_ep && dev_addr_ff[1][DEV_EN_BIT]
      && dev_addr_ff[1][6:0] == tok_addr
      && tok_endp <= TOP_EP_B;
    // SETUP only reaches a control endpoint
    tok_take = (hit_a || hit_b) && tok_kind != TOK_NONE
      && (tok_endp == 4'h0 || tok_kind != TOK_SETUP);
    tok_slot = hit_a ? tok_endp[2:0] : (tok_endp[0] ? SLOT_B1 : SLOT_B0);
    byte_take = rx_valid && ready_ff && active_ff;
  end

  // ****************************************
  // Transaction tracking
  // ****************************************
  always_comb
  begin
    nxt_active = active_ff;
    nxt_slot = slot_ff;
    nxt_kind = kind_ff;
    nxt_txn_cfg = txn_cfg_ff;
    nxt_mode = mode_ff;
    if (txn_end)
    begin
      nxt_active = 1'b0;
      nxt_mode = 4'h0;
    end
    if (tok_take)
    begin
      nxt_active = 1'b1;
      nxt_slot = tok_slot;
      nxt_kind = tok_kind;
      nxt_txn_cfg = cfg_ff;
      nxt_mode = 4'h0;
      if (tok_slot == SLOT_A0)
        nxt_mode = ep0_ff[0][3:0];
      else if (tok_slot == SLOT_B0 || tok_slot == SLOT_A3 && five_ep)
        nxt_mode = ep0_ff[1][3:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      active_ff <= 1'b0;
      slot_ff <= SLOT_A0;
      kind_ff <= TOK_NONE;
      txn_cfg_ff <= 2'h0;
      mode_ff <= 4'h0;
    end
    else
    begin
      active_ff <= nxt_active;
      slot_ff <= nxt_slot;
      kind_ff <= nxt_kind;
      txn_cfg_ff <= nxt_txn_cfg;
      mode_ff <= nxt_mode;
    end
  end

  // ****************************************
  // Address and endpoint zero registers
  // ****************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_dev
    logic ctl;
    logic tok_hit;
    logic ack_hit;
    logic hw;
    always_comb
    begin
      nxt_dev_addr[i] = dev_addr_ff[i];
      if (io_wr && sel[2 * i])
        nxt_dev_addr[i] = io_wdata;
      ctl = (i == 0) || !five_ep;
      tok_hit = ctl && tok_take && tok_slot == CTRL_SLOT[i];
      ack_hit = txn_ack && active_ff
        && slot_ff == (ctl ? CTRL_SLOT[i] : SLOT_A3);
      hw = ctl && (tok_hit || ack_hit);
      nxt_ep0[i] = ep0_ff[i];
      if (io_wr && sel[2 * i + 1])
      begin
        if (!ctl)
          nxt_ep0[i] = io_wdata;
        else
        begin
          nxt_ep0[i][FLAG_SETUP] = 1'b0;
          if (!lock_ff[i])
            nxt_ep0[i][6:0] = io_wdata[6:0];
        end
      end
      // Engine sets win over CPU writes
      if (tok_hit && tok_kind == TOK_OUT)
        nxt_ep0[i][FLAG_OUT] = 1'b1;
      if (tok_hit && tok_kind == TOK_IN)
        nxt_ep0[i][FLAG_IN] = 1'b1;
      if (tok_hit && tok_kind == TOK_SETUP)
        nxt_ep0[i][FLAG_SETUP] = 1'b1;
      // SETUP held high while its transaction runs
      if (ctl && active_ff && kind_ff == TOK_SETUP && slot_ff == CTRL_SLOT[i])
        nxt_ep0[i][FLAG_SETUP] = 1'b1;
      if (ack_hit)
        nxt_ep0[i][FLAG_ACK] = 1'b1;
      nxt_lock[i] = ctl && (hw || lock_ff[i] && !(io_rd && sel[2 * i + 1]));
    end

    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        dev_addr_ff[i] <= RESET_BYTE;
        ep0_ff[i] <= RESET_BYTE;
        lock_ff[i] <= 1'b0;
      end
      else
      begin
        dev_addr_ff[i] <= nxt_dev_addr[i];
        ep0_ff[i] <= nxt_ep0[i];
        lock_ff[i] <= nxt_lock[i];
      end
    end
  end

  // ****************************************
  // Configuration and read port
  // ****************************************
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (io_wr && sel[SEL_CTRL])
      nxt_cfg = {io_wdata[CTRL_SIZE_BIT], io_wdata[CTRL_COUNT_BIT]};
    nxt_rdata = RESET_BYTE;
    if (io_rd)
    begin
      if (sel[SEL_DEV_A])
        nxt_rdata = dev_addr_ff[0];
      if (sel[SEL_EP0_A])
        nxt_rdata = ep0_ff[0];
      if (sel[SEL_DEV_B])
        nxt_rdata = dev_addr_ff[1];
      if (sel[SEL_EP0_B])
        nxt_rdata = ep0_ff[1];
      if (sel[SEL_CTRL])
      begin
        nxt_rdata[CTRL_SIZE_BIT] = cfg_ff[CFG_SIZE];
        nxt_rdata[CTRL_COUNT_BIT] = cfg_ff[CFG_COUNT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_ff <= 2'h0;
      rdata_ff <= RESET_BYTE;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // FIFO writer with processor stall
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = tok_take ? 6'h00 : idx_ff;
    nxt_we = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        // Bytes beyond the FIFO size are dropped
        if (byte_take && idx_ff < slot_size(txn_cfg_ff, slot_ff))
        begin
          nxt_we = 1'b1;
          nxt_waddr = 8'(RAM_BASE[txn_cfg_ff][slot_ff] + {2'h0, idx_ff});
          nxt_wdata = rx_data;
          nxt_idx = 6'(idx_ff + 6'h01);
          nxt_state = ST_BUSY;
          nxt_cnt = 2'h1;
        end
      end
      ST_BUSY:
      begin
        if (cnt_ff == BYTE_STALL_CYCLES)
          nxt_state = ST_IDLE;
        else
          nxt_cnt = 2'(cnt_ff + 2'h1);
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'h0;
      idx_ff <= 6'h00;
      we_ff <= 1'b0;
      waddr_ff <= RESET_BYTE;
      wdata_ff <= RESET_BYTE;
      stall_ff <= 1'b0;
      ready_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      we_ff <= nxt_we;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      stall_ff <= nxt_state == ST_BUSY;
      ready_ff <= nxt_state == ST_IDLE;
    end
  end

  assign io_rdata = rdata_ff;
  assign rx_ready = ready_ff;
  assign txn_hit = active_ff;
  assign txn_slot = slot_ff;
  assign txn_mode = mode_ff;
  assign ram_we = we_ff;
  assign ram_addr = waddr_ff;
  assign ram_wdata = wdata_ff;
  assign cpu_stall = stall_ff;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_stall3;
    stall_ff [*3] ##1 !stall_ff;
  endsequence

  property p_reset_clear;
    @(posedge clk) !nrst |=> dev_addr_ff[0] == 8'h00 && dev_addr_ff[1] == 8'h00
      && ep0_ff[0] == 8'h00 && ep0_ff[1] == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("regs not cleared");

  property p_disabled;
    @(posedge clk) disable iff (!nrst)
      tok_valid && !dev_addr_ff[0][7] && !dev_addr_ff[1][7] && !active_ff |=> !txn_hit;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled address answered");

  property p_stall;
    @(posedge clk) disable iff (!nrst) nxt_we |=> ram_we ##0 s_stall3;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not three cycles");

  property p_five_b;
    @(posedge clk) disable iff (!nrst)
      tok_valid && five_ep && !hit_a |=> txn_hit == $past(active_ff && !txn_end);
  endproperty
  a_five_b: assert property (p_five_b) else $error("address B answered");

  property p_out_flag;
    @(posedge clk) disable iff (!nrst)
      tok_take && tok_slot == SLOT_A0 && tok_kind == TOK_OUT |=> ep0_ff[0][5] && lock_ff[0];
  endproperty
  a_out_flag: assert property (p_out_flag) else $error("OUT flag missing");

  property p_setup_hold;
    @(posedge clk) disable iff (!nrst)
      active_ff && slot_ff == SLOT_A0 && kind_ff == TOK_SETUP |-> ep0_ff[0][7];
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("SETUP dropped");

  property p_ack;
    @(posedge clk) disable iff (!nrst)
      txn_ack && active_ff && slot_ff == SLOT_A0 |=> ep0_ff[0][4];
  endproperty
  a_ack: assert property (p_ack) else $error("ACK flag missing");

  property p_lock;
    @(posedge clk) disable iff (!nrst)
      lock_ff[0] && io_wr && sel[SEL_EP0_A] && !io_rd && !tok_valid && !txn_ack
      |=> ep0_ff[0][6:0] == $past(ep0_ff[0][6:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits written");

  property p_map_default;
    @(posedge clk) disable iff (!nrst)
      nxt_we && txn_cfg_ff == 2'h0 && slot_ff == SLOT_A0 |=> ram_addr[7:3] == 5'h1f;
  endproperty
  a_map_default: assert property (p_map_default) else $error("A0 misplaced");

  property p_size32;
    @(posedge clk) disable iff (!nrst)
      nxt_we && txn_cfg_ff[1] && slot_ff == SLOT_A2 |=> ram_addr >= 8'he0;
  endproperty
  a_size32: assert property (p_size32) else $error("A2 large FIFO misplaced");

  property p_cfg_keep;
    @(posedge clk) disable iff (!nrst)
      active_ff && !tok_take |=> txn_cfg_ff == $past(txn_cfg_ff);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("config changed mid transfer");
endmodule
`default_nettype wire

// ==== usb_host_model.sv ====
// Behavioural host side model: tokens, handshakes and received bytes
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
  input wire logic clk,
  output var logic tok_valid,
  output var usb_sie_pkg::tok_kind_t tok_kind,
  output var usb_sie_pkg::dev_addr_t tok_addr,
  output var usb_sie_pkg::endp_t tok_endp,
  output var logic txn_ack,
  output var logic txn_done,
  output var logic rx_valid,
  output var usb_sie_pkg::byte_t rx_data,
  input wire logic rx_ready
);
  import usb_sie_pkg::*;
  initial
  begin
    tok_valid = 1'b0;
    tok_kind = TOK_NONE;
    tok_addr = 7'h00;
    tok_endp = 4'h0;
    txn_ack = 1'b0;
    txn_done = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // ****************************************
  // Token phase, fields scrambled when idle
  // ****************************************
  task automatic token(input tok_kind_t k, input dev_addr_t a, input endp_t e);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_addr <= a;
    tok_endp <= e;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_kind <= TOK_NONE;
    tok_addr <= ~a;
    tok_endp <= ~e;
  endtask
  task automatic finish(input logic ok);
    @(posedge clk);
    txn_ack <= ok;
    txn_done <= ~ok;
    @(posedge clk);
    txn_ack <= 1'b0;
    txn_done <= 1'b0;
  endtask
  // ****************************************
  // Data byte, held until taken
  // ****************************************
  task automatic send(input byte_t d, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    @(posedge clk);
    while (rx_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== usb_sie_address_endpoint_config_tb_top.sv ====
// Testbench for address match, endpoint zero flags and FIFO placement
`timescale 1ns/1ps
`default_nettype none
module usb_sie_address_endpoint_config_tb_top;
  import usb_sie_pkg::*;
  logic clk, nrst, io_wr, io_rd, rx_ready, txn_hit, ram_we, cpu_stall;
  logic tok_valid, txn_ack, txn_done, rx_valid;
  io_addr_t io_addr;
  byte_t io_wdata, io_rdata, rx_data, ram_addr, ram_wdata;
  tok_kind_t tok_kind;
  dev_addr_t tok_addr;
  endp_t tok_endp;
  slot_t txn_slot;
  mode_t txn_mode;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  usb_sie_endpoint_map u_usb_sie_endpoint_map (.clk, .nrst, .io_addr, .io_wdata, .io_wr,
    .io_rd, .io_rdata, .tok_valid, .tok_kind, .tok_addr, .tok_endp, .txn_ack, .txn_done,
    .rx_valid, .rx_data, .rx_ready, .txn_hit, .txn_slot, .txn_mode, .ram_we, .ram_addr,
    .ram_wdata, .cpu_stall);
  usb_host_model u_usb_host_model (.clk, .tok_valid, .tok_kind, .tok_addr, .tok_endp,
    .txn_ack, .txn_done, .rx_valid, .rx_data, .rx_ready);
  always #20 clk = ~clk;
  // ****************************************
  // Shared checks and bus cycles
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input io_addr_t a, input byte_t d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input io_addr_t a, input byte_t exp);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    check(io_rdata, exp);
  endtask
  task automatic tok(input tok_kind_t k, input dev_addr_t a, input endp_t e, input logic hit,
                     input slot_t s, input mode_t m);
    u_usb_host_model.token(k, a, e);
    #1;
    check(8'(txn_hit), 8'(hit));
    if (hit)
    begin
      check(8'(txn_slot), 8'(s));
      check(8'(txn_mode), 8'(m));
    end
  endtask
  task automatic miss(input tok_kind_t k, input dev_addr_t a, input endp_t e);
    tok(k, a, e, 1'b0, SLOT_A0, 4'h0);
  endtask
  task automatic fin(input logic ok);
    u_usb_host_model.finish(ok);
    #1;
    check(8'(txn_hit), 8'h00);
  endtask
  task automatic put(input byte_t d, input logic we, input byte_t a, input int gap);
    u_usb_host_model.send(d, gap);
    #1;
    check(8'(ram_we), 8'(we));
    if (we)
    begin
      check(ram_addr, a);
      check(ram_wdata, d);
      for (int k = 0; k < 3; k++)
      begin
        check(8'(cpu_stall), 8'h01);
        check(8'(rx_ready), 8'h00);
        @(posedge clk);
        #1;
      end
      check(8'(cpu_stall), 8'h00);
      check(8'(rx_ready), 8'h01);
    end
  endtask
  task automatic t_map(input dev_addr_t a, input endp_t e, input slot_t s, input byte_t base,
                       input mode_t m);
    tok(TOK_OUT, a, e, 1'b1, s, m);
    put(8'h3c, 1'b1, base, 0);
    put(8'hc3, 1'b1, base + 8'h01, 2);
    fin(1'b1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_addr();
    wr(ADDR_DEV_A, 8'h05);
    miss(TOK_OUT, 7'h05, 4'h0);
    wr(ADDR_DEV_A, 8'h85);
    wr(ADDR_DEV_B, 8'h86);
    wr(8'h11, 8'h55);
    rd(8'h11, 8'h00);
    rd(ADDR_DEV_A, 8'h85);
    rd(ADDR_DEV_B, 8'h86);
    @(posedge clk);
    #1;
    check(io_rdata, 8'h00);
    miss(TOK_IN, 7'h07, 4'h0);
    miss(TOK_OUT, 7'h05, 4'h3);
    miss(TOK_OUT, 7'h06, 4'h2);
    miss(TOK_SETUP, 7'h05, 4'h1);
  endtask
  task automatic t_flags(input io_addr_t r, input dev_addr_t a, input slot_t s);
    tok(TOK_OUT, a, 4'h0, 1'b1, s, 4'h0);
    rd(r, 8'h20);
    fin(1'b1);
    rd(r, 8'h30);
    wr(r, 8'h00);
    rd(r, 8'h00);
    tok(TOK_IN, a, 4'h0, 1'b1, s, 4'h0);
    wr(r, 8'h03);
    rd(r, 8'h40);
    fin(1'b0);
    rd(r, 8'h40);
    wr(r, 8'h03);
    rd(r, 8'h03);
    tok(TOK_SETUP, a, 4'h0, 1'b1, s, 4'h3);
    rd(r, 8'h83);
    wr(r, 8'h00);
    rd(r, 8'h80);
    fin(1'b1);
    wr(r, 8'h01);
    rd(r, 8'h10);
    wr(r, 8'h00);
    rd(r, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check(8'(rx_ready), 8'h01);
    rd(ADDR_DEV_A, RESET_BYTE);
    rd(ADDR_DEV_B, RESET_BYTE);
    rd(ADDR_EP0_A, RESET_BYTE);
    rd(ADDR_EP0_B, RESET_BYTE);
    rd(ADDR_USB_CTRL, RESET_BYTE);
    miss(TOK_OUT, 7'h00, 4'h0);
    t_addr();
    t_flags(ADDR_EP0_A, 7'h05, SLOT_A0);
    t_flags(ADDR_EP0_B, 7'h06, SLOT_B0);
    t_map(7'h05, 4'h0, SLOT_A0, 8'hf8, 4'h0);
    t_map(7'h05, 4'h1, SLOT_A1, 8'hf0, 4'h0);
    t_map(7'h05, 4'h2, SLOT_A2, 8'he8, 4'h0);
    t_map(7'h06, 4'h0, SLOT_B0, 8'he0, 4'h0);
    t_map(7'h06, 4'h1, SLOT_B1, 8'hd8, 4'h0);
    wr(ADDR_USB_CTRL, 8'h9f);
    rd(ADDR_USB_CTRL, 8'h80);
    tok(TOK_OUT, 7'h05, 4'h1, 1'b1, SLOT_A1, 4'h0);
    for (int i = 0; i < 9; i++)
      put(8'(i), 1'b1, 8'hc0 + 8'(i), 0);
    fin(1'b1);
    tok(TOK_OUT, 7'h05, 4'h0, 1'b1, SLOT_A0, 4'h0);
    for (int i = 0; i < 9; i++)
      put(8'(i), i < 8, 8'hb8 + 8'(i), 0);
    fin(1'b1);
    t_map(7'h05, 4'h2, SLOT_A2, 8'he0, 4'h0);
    t_map(7'h06, 4'h0, SLOT_B0, 8'ha8, 4'h0);
    t_map(7'h06, 4'h1, SLOT_B1, 8'hb0, 4'h0);
    wr(ADDR_USB_CTRL, 8'h40);
    miss(TOK_OUT, 7'h06, 4'h0);
    wr(ADDR_EP0_B, 8'h0a);
    rd(ADDR_EP0_B, 8'h0a);
    t_map(7'h05, 4'h3, SLOT_A3, 8'he0, 4'ha);
    rd(ADDR_EP0_B, 8'h1a);
    t_map(7'h05, 4'h4, SLOT_A4, 8'hd8, 4'h0);
    miss(TOK_OUT, 7'h05, 4'h5);
    wr(ADDR_USB_CTRL, 8'hc0);
    tok(TOK_OUT, 7'h05, 4'h3, 1'b1, SLOT_A3, 4'ha);
    put(8'h11, 1'b1, 8'ha8, 0);
    wr(ADDR_USB_CTRL, 8'h40);
    put(8'h22, 1'b1, 8'ha9, 1);
    fin(1'b1);
    final_report();
  end
endmodule
`default_nettype wire
